// >>> acc_pkg.sv
package acc_pkg;

    // ==================================================================
    // Register byte addresses.
    localparam logic [7:0] ACC_ADDR_RES_LOW = 8'h78;
    localparam logic [7:0] ACC_ADDR_RES_HIGH = 8'h79;
    localparam logic [7:0] ACC_ADDR_CTRL = 8'h7a;
    localparam logic [7:0] ACC_ADDR_CTRL2 = 8'h7b;
    localparam logic [7:0] ACC_ADDR_INSEL = 8'h7c;

    // ==================================================================
    // Reset values.
    localparam logic [7:0] ACC_CTRL_RST = 8'h00;
    localparam logic [7:0] ACC_INSEL_RST = 8'h00;
    localparam logic [2:0] ACC_TRIG_RST = 3'h0;

    // ==================================================================
    // Control and status register fields.
    localparam int ACC_CTRL_EN_BIT = 7;
    localparam int ACC_CTRL_START_BIT = 6;
    localparam int ACC_CTRL_ATE_BIT = 5;
    localparam int ACC_CTRL_DONE_BIT = 4;
    localparam int ACC_CTRL_IE_BIT = 3;
    localparam int ACC_CTRL_PS_LSB = 0;

    // ==================================================================
    // Input select register fields.
    localparam int ACC_INSEL_REF_LSB = 6;
    localparam int ACC_INSEL_LEFT_BIT = 5;
    localparam int ACC_INSEL_CHAN_LSB = 0;

    // Trigger source code for free running conversions.
    localparam logic [2:0] ACC_TRIG_FREE = 3'h0;

    // ==================================================================
    // Conversion lengths in converter clock cycles, and the prescaler counter width.
    localparam logic [4:0] ACC_FIRST_LEN = 5'd25;
    localparam logic [4:0] ACC_NORM_LEN = 5'd13;
    localparam int ACC_PRE_W = 7;

    // ==================================================================
    // Decoded input routing towards the analog core.
    typedef enum logic [3:0] {
        ACC_IN_SINGLE = 4'b0001,
        ACC_IN_DIFF = 4'b0010,
        ACC_IN_BANDGAP = 4'b0100,
        ACC_IN_GROUND = 4'b1000
    } acc_in_mode_e;

    typedef enum logic [2:0] {
        ACC_GAIN_1X = 3'b001,
        ACC_GAIN_10X = 3'b010,
        ACC_GAIN_200X = 3'b100
    } acc_gain_e;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        ACC_ST_IDLE = 2'b01,
        ACC_ST_CONV = 2'b10
    } acc_state_e;

endpackage

// >>> acc_converter_ctrl.sv
// Notes on behaviour
// - Reference field picks external, supply, 1.1V, 2.56V.
// - Reference and channel changes wait for conversion end.
// - Adjust bit realigns result immediately, even mid-conversion.
// - Codes 0-7 single inputs, 30 bandgap, 31 ground.
// - Differential codes select gain and negative input.
// - Enable powers converter; clearing aborts conversion.
// - Start bit begins single or first free-running conversion.
// - First conversion after enable takes 25, else 13.
// - Start bit reads one while busy; zero ignored.
// - Auto trigger starts conversion on trigger rising edge.
// - Done flag sets at every conversion end, even with result locked.
// - Done flag cleared by vector taken or writing one.
// - Interrupt requested when flag, enable, global enable set.
// - Prescaler code divides system clock by 2 to 128.
// - Trigger source zero is free running, no trigger.
// - Low byte read locks result until high byte read.
// - Result presented at two bytes, left or right aligned.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module acc_converter_ctrl (
    // Clock, reset and clock enable.
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Processor interrupt handshake.
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic conv_irq_req,
    // Auto trigger sources, index 1 to 7 used, index 0 unused.
    input wire logic [7:0] trigger_in,
    // Analog core side.
    input wire logic [9:0] core_result,
    output logic core_power,
    output logic core_conv_clk,
    output logic core_sample,
    output logic core_busy,
    output logic [1:0] core_ref_sel,
    output acc_pkg::acc_in_mode_e core_in_mode,
    output logic [2:0] core_pos_input,
    output logic [2:0] core_neg_input,
    output acc_pkg::acc_gain_e core_gain
);
    import acc_pkg::*;

    // ==================================================================
    // State.
    logic enable_r;
    logic ate_r;
    logic ie_r;
    logic done_r;
    logic [2:0] ps_r;
    logic [7:0] insel_r;
    logic [2:0] trig_sel_r;
    logic [1:0] ref_app_r;
    logic [4:0] chan_app_r;
    logic [ACC_PRE_W-1:0] pre_cnt_r;
    logic [4:0] cyc_r;
    logic long_r;
    logic first_pend_r;
    logic trig_prev_r;
    logic [9:0] result_r;
    logic lock_r;
    acc_state_e state_r;
    logic [7:0] rdata_r;
    logic irq_r;
    logic power_r;
    logic conv_clk_r;
    logic sample_r;
    logic busy_r;
    logic [1:0] ref_out_r;
    acc_in_mode_e mode_r;
    logic [2:0] pos_r;
    logic [2:0] neg_r;
    acc_gain_e gain_r;

    // ==================================================================
    // Register decode.
    wire ctrl_wr = reg_wr && (reg_addr == ACC_ADDR_CTRL);
    wire ctrl2_wr = reg_wr && (reg_addr == ACC_ADDR_CTRL2);
    wire insel_wr = reg_wr && (reg_addr == ACC_ADDR_INSEL);
    wire low_rd = reg_rd && (reg_addr == ACC_ADDR_RES_LOW);
    wire high_rd = reg_rd && (reg_addr == ACC_ADDR_RES_HIGH);
    wire [7:0] insel_nxt = insel_wr ? reg_wdata : insel_r;
    wire en_nxt = ctrl_wr ? reg_wdata[ACC_CTRL_EN_BIT] : enable_r;
    wire left_adj = insel_r[ACC_INSEL_LEFT_BIT];
    wire busy = (state_r == ACC_ST_CONV);

    // ==================================================================
    // Prescaler: a free running counter; the converter tick comes when
    // all counter bits below the divide ratio are ones. Codes zero and
    // one both divide by two. Changing the code mid-conversion only
    // shifts tick spacing, it never stops the sequencer.
    wire [2:0] ps_shift = (ps_r == 3'h0) ? 3'h1 : ps_r;
    wire [ACC_PRE_W-1:0] pre_mask = ACC_PRE_W'((8'h01 << ps_shift) - 8'h01);
    wire [ACC_PRE_W-1:0] pre_half = pre_mask ^ (pre_mask >> 1);
    wire [ACC_PRE_W-1:0] pre_cnt_nxt = pre_cnt_r + ACC_PRE_W'(1);
    wire conv_tick = ((pre_cnt_r & pre_mask) == pre_mask);

    // ==================================================================
    // Trigger selection and rising edge detection. Source zero feeds a
    // constant low, so switching to free running never makes an edge.
    wire trig_level = (trig_sel_r == ACC_TRIG_FREE) ? 1'b0 : trigger_in[trig_sel_r];
    wire trig_edge = trig_level && !trig_prev_r;

    // ==================================================================
    // Conversion sequencing.
    wire [4:0] conv_last = (long_r ? ACC_FIRST_LEN : ACC_NORM_LEN) - 5'd1;
    wire conv_end = busy && conv_tick && (cyc_r == conv_last);
    wire abort = busy && !en_nxt;
    wire sw_start = ctrl_wr && reg_wdata[ACC_CTRL_START_BIT] && reg_wdata[ACC_CTRL_EN_BIT];
    wire hw_start = enable_r && ate_r && trig_edge;
    wire free_run = ate_r && (trig_sel_r == ACC_TRIG_FREE);
    wire restart = conv_end && free_run;
    wire start_go = en_nxt && ((!busy && (sw_start || hw_start)) || restart);
    wire enable_rise = ctrl_wr && reg_wdata[ACC_CTRL_EN_BIT] && !enable_r;
    wire first_nxt = enable_rise || first_pend_r;
    wire apply_sel = !busy || conv_end;

    // Done flag: a completing conversion wins over either clear.
    wire done_clr = irq_vector_taken || (ctrl_wr && reg_wdata[ACC_CTRL_DONE_BIT]);
    wire done_nxt = conv_end || (done_r && !done_clr);

    // ==================================================================
    // Result presentation; the adjust bit acts on the stored result so
    // a change shows at once, even mid-conversion.
    wire [7:0] res_low = left_adj ? {result_r[1:0], 6'h00} : result_r[7:0];
    wire [7:0] res_high = left_adj ? result_r[9:2] : {6'h00, result_r[9:8]};
    wire [7:0] ctrl_rd_val = {enable_r, busy, ate_r, done_r, ie_r, ps_r};
    wire [7:0] ctrl2_rd_val = {5'h00, trig_sel_r};
    wire [7:0] rd_mux = (reg_addr == ACC_ADDR_RES_LOW) ? res_low :
                        (reg_addr == ACC_ADDR_RES_HIGH) ? res_high :
                        (reg_addr == ACC_ADDR_CTRL) ? ctrl_rd_val :
                        (reg_addr == ACC_ADDR_CTRL2) ? ctrl2_rd_val :
                        (reg_addr == ACC_ADDR_INSEL) ? insel_r : 8'h00;

    // ==================================================================
    // Channel decode of the applied code towards the analog core.
    wire [4:0] chan_nxt = apply_sel ? insel_nxt[ACC_INSEL_CHAN_LSB +: 5] : chan_app_r;
    wire [1:0] ref_nxt = apply_sel ? insel_nxt[ACC_INSEL_REF_LSB +: 2] : ref_app_r;
    acc_in_mode_e mode_nxt;
    acc_gain_e gain_nxt;
    logic [2:0] pos_nxt;
    logic [2:0] neg_nxt;

    // Single codes, gain pairs, unity pairs, then the two fixed sources.
    always_comb begin
        mode_nxt = ACC_IN_SINGLE;
        gain_nxt = ACC_GAIN_1X;
        pos_nxt = chan_nxt[2:0];
        neg_nxt = 3'h0;
        case (chan_nxt[4:3])
            2'b00: begin
                mode_nxt = ACC_IN_SINGLE;
            end
            2'b01: begin
                mode_nxt = ACC_IN_DIFF;
                gain_nxt = chan_nxt[1] ? ACC_GAIN_200X : ACC_GAIN_10X;
                pos_nxt = {1'b0, chan_nxt[2], chan_nxt[0]};
                neg_nxt = {1'b0, chan_nxt[2], 1'b0};
            end
            2'b10: begin
                mode_nxt = ACC_IN_DIFF;
                neg_nxt = 3'h1;
            end
            2'b11: begin
                if (chan_nxt[2:1] == 2'b11) begin
                    mode_nxt = chan_nxt[0] ? ACC_IN_GROUND : ACC_IN_BANDGAP;
                    pos_nxt = 3'h0;
                end else begin
                    mode_nxt = ACC_IN_DIFF;
                    neg_nxt = 3'h2;
                end
            end
            default: begin
                mode_nxt = ACC_IN_SINGLE;
            end
        endcase
    end

    // ==================================================================
    // Software visible control bits.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            enable_r <= ACC_CTRL_RST[ACC_CTRL_EN_BIT];
            ate_r <= ACC_CTRL_RST[ACC_CTRL_ATE_BIT];
            ie_r <= ACC_CTRL_RST[ACC_CTRL_IE_BIT];
            ps_r <= ACC_CTRL_RST[ACC_CTRL_PS_LSB +: 3];
            insel_r <= ACC_INSEL_RST;
            trig_sel_r <= ACC_TRIG_RST;
            done_r <= ACC_CTRL_RST[ACC_CTRL_DONE_BIT];
        end else if (clk_en) begin
            enable_r <= en_nxt;
            insel_r <= insel_nxt;
            done_r <= done_nxt;
            if (ctrl_wr) begin
                ate_r <= reg_wdata[ACC_CTRL_ATE_BIT];
                ie_r <= reg_wdata[ACC_CTRL_IE_BIT];
                ps_r <= reg_wdata[ACC_CTRL_PS_LSB +: 3];
            end
            if (ctrl2_wr) begin
                trig_sel_r <= reg_wdata[2:0];
            end
        end
    end

    // ==================================================================
    // Prescaler counter and trigger history.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pre_cnt_r <= '0;
            trig_prev_r <= 1'b0;
        end else if (clk_en) begin
            pre_cnt_r <= pre_cnt_nxt;
            trig_prev_r <= trig_level;
        end
    end

    // ==================================================================
    // Sequencer. An abort outranks everything, so a disable in the same
    // write as a start leaves the block idle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ACC_ST_IDLE;
            cyc_r <= 5'd0;
            long_r <= 1'b0;
            first_pend_r <= 1'b0;
        end else if (clk_en) begin
            first_pend_r <= start_go ? 1'b0 : first_nxt;
            case (state_r)
                ACC_ST_IDLE: begin
                    if (start_go) begin
                        state_r <= ACC_ST_CONV;
                        cyc_r <= 5'd0;
                        long_r <= first_nxt;
                    end
                end
                ACC_ST_CONV: begin
                    if (abort) begin
                        state_r <= ACC_ST_IDLE;
                    end else if (restart) begin
                        cyc_r <= 5'd0;
                        long_r <= 1'b0;
                    end else if (conv_end) begin
                        state_r <= ACC_ST_IDLE;
                    end else if (conv_tick) begin
                        cyc_r <= cyc_r + 5'd1;
                    end
                end
                default: begin
                    state_r <= ACC_ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Result holding and read lock. A conversion that ends while the
    // lock is held loses its result, though the done flag still sets.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            result_r <= 10'h000;
            lock_r <= 1'b0;
        end else if (clk_en) begin
            if (conv_end && !lock_r) begin
                result_r <= core_result;
            end
            if (high_rd) begin
                lock_r <= 1'b0;
            end else if (low_rd) begin
                lock_r <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Applied selections and read data; read data stand one cycle only.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ref_app_r <= ACC_INSEL_RST[ACC_INSEL_REF_LSB +: 2];
            chan_app_r <= ACC_INSEL_RST[ACC_INSEL_CHAN_LSB +: 5];
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            ref_app_r <= ref_nxt;
            chan_app_r <= chan_nxt;
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ==================================================================
    // Registered outputs towards the core and the processor.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_r <= 1'b0;
            power_r <= 1'b0;
            conv_clk_r <= 1'b0;
            sample_r <= 1'b0;
            busy_r <= 1'b0;
            ref_out_r <= 2'h0;
            mode_r <= ACC_IN_SINGLE;
            pos_r <= 3'h0;
            neg_r <= 3'h0;
            gain_r <= ACC_GAIN_1X;
        end else if (clk_en) begin
            irq_r <= done_nxt && ie_r && global_irq_enable;
            power_r <= en_nxt;
            conv_clk_r <= |(pre_cnt_nxt & pre_half);
            sample_r <= start_go;
            busy_r <= start_go || (busy && !abort && !conv_end);
            ref_out_r <= ref_nxt;
            mode_r <= mode_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            gain_r <= gain_nxt;
        end
    end

    // Ports.
    assign reg_rdata = rdata_r;
    assign conv_irq_req = irq_r;
    assign core_power = power_r;
    assign core_conv_clk = conv_clk_r;
    assign core_sample = sample_r;
    assign core_busy = busy_r;
    assign core_ref_sel = ref_out_r;
    assign core_in_mode = mode_r;
    assign core_pos_input = pos_r;
    assign core_neg_input = neg_r;
    assign core_gain = gain_r;

endmodule

`default_nettype wire

// >>> acc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// Analog core stand-in: the result encodes the applied selection.
module acc_core_model (
    // Clock and selection from the controller.
    input wire logic sys_clk,
    input wire logic core_power,
    input wire logic [1:0] core_ref_sel,
    input wire logic [2:0] core_pos_input,
    input wire logic [2:0] core_neg_input,
    // Result towards the controller.
    output logic [9:0] core_result
);
    logic [9:0] junk_r = 10'h155;

    // Unpowered, the core drives a pattern that flips every cycle, so a stale latch shows.
    always_ff @(posedge sys_clk) begin
        junk_r <= ~junk_r;
    end

    // Tracking the applied selection proves which setting a conversion really used.
    assign core_result = core_power ? {core_ref_sel, core_pos_input, core_neg_input, 2'b01} : junk_r;
endmodule

`default_nettype wire

// >>> acc_converter_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// Port checker for the converter controller.
module acc_converter_ctrl_asserts
    import acc_pkg::*;
(
    // Clock, reset and bus.
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Interrupt and core side.
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic conv_irq_req,
    input wire logic core_power,
    input wire logic core_sample,
    input wire logic core_busy,
    input wire logic [1:0] core_ref_sel,
    input wire logic [2:0] core_pos_input,
    input wire logic [2:0] core_neg_input
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    logic [11:0] busy_len_r;
    logic [11:0] busy_len_nxt;
    wire ctrl_wr = reg_wr && clk_en && (reg_addr == ACC_ADDR_CTRL);

    // Length of the current busy run; saturates so it never wraps.
    assign busy_len_nxt = !core_busy ? 12'h000 : (busy_len_r == 12'hfff) ? busy_len_r : busy_len_r + 12'h001;
    always_ff @(posedge sys_clk) begin
        busy_len_r <= srst ? 12'h000 : busy_len_nxt;
    end

    // A pending selection stays put while the core samples.
    sequence sel_steady;
        ($stable(core_ref_sel) && $stable(core_pos_input) && $stable(core_neg_input)) || !core_power;
    endsequence

    power_follow_a: assert property (ctrl_wr |=> core_power == $past(reg_wdata[7]))
        else $error("power does not follow enable bit");
    abort_stop_a: assert property (ctrl_wr && !reg_wdata[7] |=> !core_busy)
        else $error("conversion not aborted");
    rdata_idle_a: assert property (!reg_rd && clk_en |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    irq_gate_a: assert property (conv_irq_req |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    irq_clear_a: assert property (irq_vector_taken && !core_busy |-> ##2 !conv_irq_req)
        else $error("vector did not clear request");
    sample_start_a: assert property ($rose(core_busy) |-> core_sample)
        else $error("busy without sample pulse");
    sample_pulse_a: assert property (core_sample |=> !core_sample)
        else $error("sample pulse too long");
    sel_hold_a: assert property (core_sample |=> sel_steady [*8])
        else $error("selection changed mid conversion");
    busy_len_a: assert property ($fell(core_busy) && core_power |-> busy_len_r >= 12'd25 && busy_len_r <= 12'd3201)
        else $error("conversion length out of range");
endmodule

bind acc_converter_ctrl acc_converter_ctrl_asserts chk_u (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken), .conv_irq_req(conv_irq_req),
    .core_power(core_power), .core_sample(core_sample), .core_busy(core_busy), .core_ref_sel(core_ref_sel),
    .core_pos_input(core_pos_input), .core_neg_input(core_neg_input));

`default_nettype wire

// >>> tb_acc_converter_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module tb_acc_converter_ctrl;
    import acc_pkg::*;
    // ==================================================================
    // Signals.
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic gie = 1'b0;
    logic vec = 1'b0;
    logic [7:0] trigger_in = 8'h00;
    logic [7:0] reg_rdata;
    logic conv_irq_req, core_power, core_conv_clk, core_sample, core_busy;
    logic [1:0] core_ref_sel;
    acc_in_mode_e core_in_mode;
    acc_gain_e core_gain;
    logic [2:0] core_pos_input, core_neg_input;
    logic [9:0] core_result;
    int n_fail = 0;
    int num_checks = 0;

    // Clock enable drops once, so that a write during a freeze is shown to be ignored.
    acc_converter_ctrl dut_u (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .global_irq_enable(gie), .irq_vector_taken(vec), .conv_irq_req(conv_irq_req), .trigger_in(trigger_in),
        .core_result(core_result), .core_power(core_power), .core_conv_clk(core_conv_clk),
        .core_sample(core_sample), .core_busy(core_busy), .core_ref_sel(core_ref_sel),
        .core_in_mode(core_in_mode), .core_pos_input(core_pos_input), .core_neg_input(core_neg_input),
        .core_gain(core_gain));
    acc_core_model core_u (.sys_clk(sys_clk), .core_power(core_power), .core_ref_sel(core_ref_sel),
        .core_pos_input(core_pos_input), .core_neg_input(core_neg_input), .core_result(core_result));

    always #10 sys_clk = ~sys_clk;

    // ==================================================================
    // Bus and checking tasks.
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, {2'b00, exp}, {2'b00, reg_rdata});
    endtask

    // Busy cycles are counted from the bench side, so a stuck busy is cut off at a bound.
    task automatic meas(input string nm, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (core_busy !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        n = 0;
        while (core_busy === 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        num_checks++;
        if (n < lo || n > hi) begin
            n_fail++;
            $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, n);
        end
    endtask

    task automatic sel_chk(input logic [7:0] code, input logic [3:0] mode, input logic [2:0] gain,
                           input logic [2:0] pos, input logic [2:0] neg);
        wr(ACC_ADDR_INSEL, code);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("ref", {8'h00, code[7:6]}, {8'h00, core_ref_sel});
        chk("mode", {6'h00, mode}, {6'h00, core_in_mode});
        if (mode[1:0] != 2'b00) begin
            chk("pos", {7'h00, pos}, {7'h00, core_pos_input});
            chk("neg", {7'h00, neg}, {7'h00, core_neg_input});
        end
        if (mode[1]) begin
            chk("gain", {7'h00, gain}, {7'h00, core_gain});
        end
    endtask

    // ==================================================================
    // Watchdog: the tests need about 4100 cycles.
    initial begin
        #(20 * 30000);
        n_fail++;
        wrap_up();
    end

    // ==================================================================
    // Main sequence.
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk("ctrl", ACC_ADDR_CTRL, ACC_CTRL_RST);
        rd_chk("insel", ACC_ADDR_INSEL, ACC_INSEL_RST);
        rd_chk("ctrl2", ACC_ADDR_CTRL2, 8'h00);
        wr(8'h7d, 8'hff);
        rd_chk("unmapped", 8'h7d, 8'h00);
        sel_chk(8'h4d, 4'b0010, 3'b010, 3'd3, 3'd2);
        sel_chk(8'hca, 4'b0010, 3'b100, 3'd0, 3'd0);
        sel_chk(8'hd4, 4'b0010, 3'b001, 3'd4, 3'd1);
        sel_chk(8'h1b, 4'b0010, 3'b001, 3'd3, 3'd2);
        sel_chk(8'h5e, 4'b0100, 3'b001, 3'd0, 3'd0);
        sel_chk(8'h1f, 4'b1000, 3'b001, 3'd0, 3'd0);
        sel_chk(8'h03, 4'b0001, 3'b001, 3'd3, 3'd0);
        // First conversion after enable, result of selection 0x03 is 0x061.
        wr(ACC_ADDR_CTRL, 8'hc0);
        meas("first len", 49, 51);
        rd_chk("ctrl", ACC_ADDR_CTRL, 8'h90);
        rd_chk("low", ACC_ADDR_RES_LOW, 8'h61);
        // Second conversion ends while the low byte read holds the result.
        wr(ACC_ADDR_INSEL, 8'h4d);
        wr(ACC_ADDR_CTRL, 8'hc0);
        rd_chk("ctrl busy", ACC_ADDR_CTRL, 8'hd0);
        wr(ACC_ADDR_INSEL, 8'hca);
        wr(ACC_ADDR_CTRL, 8'h80);
        #1;
        chk("busy", 10'h001, {9'h000, core_busy});
        chk("ref held", 10'h001, {8'h00, core_ref_sel});
        meas("rest", 1, 60);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("ref late", 10'h003, {8'h00, core_ref_sel});
        chk("gain late", 10'h004, {7'h00, core_gain});
        rd_chk("high locked", ACC_ADDR_RES_HIGH, 8'h00);
        rd_chk("low kept", ACC_ADDR_RES_LOW, 8'h61);
        rd_chk("high kept", ACC_ADDR_RES_HIGH, 8'h00);
        // Third conversion, selection 0xca gives 0x301.
        wr(ACC_ADDR_CTRL, 8'hc0);
        meas("norm len", 25, 27);
        rd_chk("low", ACC_ADDR_RES_LOW, 8'h01);
        rd_chk("high", ACC_ADDR_RES_HIGH, 8'h03);
        wr(ACC_ADDR_INSEL, 8'hea);
        rd_chk("low left", ACC_ADDR_RES_LOW, 8'h40);
        rd_chk("high left", ACC_ADDR_RES_HIGH, 8'hc0);
        // Done flag, write-one clear and interrupt request.
        wr(ACC_ADDR_CTRL, 8'h98);
        rd_chk("done clr", ACC_ADDR_CTRL, 8'h88);
        wr(ACC_ADDR_CTRL, 8'hc8);
        meas("irq len", 25, 27);
        chk("irq gated", 10'h000, {9'h000, conv_irq_req});
        gie <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq", 10'h001, {9'h000, conv_irq_req});
        @(posedge sys_clk);
        vec <= 1'b1;
        @(posedge sys_clk);
        vec <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq clr", 10'h000, {9'h000, conv_irq_req});
        rd_chk("ctrl", ACC_ADDR_CTRL, 8'h88);
        gie <= 1'b0;
        // Every prescaler code, 13 ticks each.
        for (int c = 0; c < 8; c++) begin
            int dv;
            time t0;
            dv = (c < 2) ? 2 : (1 << c);
            wr(ACC_ADDR_CTRL, 8'hc0 | 8'(c));
            meas("div len", 12 * dv + 1, 13 * dv + 1);
            // The converter clock period is the divide ratio in system clock cycles.
            @(posedge core_conv_clk);
            t0 = $time;
            @(posedge core_conv_clk);
            chk("clk period", 10'(dv), 10'(($time - t0) / 20));
        end
        // Abort by clearing enable.
        wr(ACC_ADDR_CTRL, 8'hc7);
        wr(ACC_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("abort busy", 10'h000, {9'h000, core_busy});
        chk("abort power", 10'h000, {9'h000, core_power});
        // Auto trigger on source 2, then free running.
        wr(ACC_ADDR_CTRL2, 8'h02);
        rd_chk("ctrl2", ACC_ADDR_CTRL2, 8'h02);
        clk_en <= 1'b0;
        wr(ACC_ADDR_CTRL2, 8'h05);
        clk_en <= 1'b1;
        rd_chk("frozen", ACC_ADDR_CTRL2, 8'h02);
        wr(ACC_ADDR_CTRL, 8'ha0);
        trigger_in <= 8'h04;
        meas("trig len", 49, 51);
        trigger_in <= 8'h00;
        wr(ACC_ADDR_CTRL2, {5'h00, ACC_TRIG_FREE});
        repeat (4) @(posedge sys_clk);
        #1;
        chk("free no trig", 10'h000, {9'h000, core_busy});
        wr(ACC_ADDR_CTRL, 8'he0);
        repeat (60) @(posedge sys_clk);
        rd_chk("free run", ACC_ADDR_CTRL, 8'hf0);
        wr(ACC_ADDR_CTRL, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
